//--- hw/ckg_clk_gate.sv
`timescale 1ns/1ns
module ckg_clk_gate (
    // Clock in
    input wire logic clk_i,
    // Enable from register
    input wire logic en_i,
    // Gated clock out
    output logic gclk_o
);
    logic en_lat;

    always_latch begin
        if (!clk_i) begin
            en_lat <= en_i;
        end
    end

    assign gclk_o = clk_i & en_lat;

endmodule

//--- hw/ckg_hoco_div.sv
`timescale 1ns/1ns
module ckg_hoco_div (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Option byte fields
    input wire logic [2:0] opt_code_i,
    input wire logic opt_b3_i,
    // Register write
    input wire logic wr_i,
    input wire logic [2:0] wr_code_i,
    // Status
    output logic [2:0] reg_code_o,
    output logic [2:0] act_code_o,
    output logic busy_o,
    output logic stall_o
);
    ckg_pkg::ckg_div_state_t state_q;
    logic [1:0] cnt_q;
    logic [2:0] reg_q;
    logic [2:0] act_q;
    logic start;

    assign start = wr_i && (state_q == ckg_pkg::DIV_IDLE)
        && ckg_pkg::code_ok(wr_code_i, opt_b3_i) && (wr_code_i != act_q);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_q <= opt_code_i;
        end else if (wr_i && (state_q == ckg_pkg::DIV_IDLE) && ckg_pkg::code_ok(wr_code_i, opt_b3_i)) begin
            reg_q <= wr_code_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= ckg_pkg::DIV_IDLE;
            cnt_q <= 2'h0;
            act_q <= opt_code_i;
        end else begin
            case (state_q)
                ckg_pkg::DIV_IDLE: begin
                    if (start) begin
                        state_q <= ckg_pkg::DIV_OLD;
                        cnt_q <= ckg_pkg::OLD_FREQ_CLKS_M1;
                    end
                end
                ckg_pkg::DIV_OLD: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= ckg_pkg::DIV_WAIT;
                        cnt_q <= ckg_pkg::NEW_WAIT_CLKS_M1;
                        act_q <= reg_q;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                ckg_pkg::DIV_WAIT: begin
                    if (cnt_q == 2'h0) begin
                        state_q <= ckg_pkg::DIV_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                default: begin
                    state_q <= ckg_pkg::DIV_IDLE;
                end
            endcase
        end
    end

    assign reg_code_o = reg_q;
    assign act_code_o = act_q;
    assign busy_o = (state_q != ckg_pkg::DIV_IDLE);
    assign stall_o = (state_q == ckg_pkg::DIV_WAIT);

endmodule

//--- hw/ckg_pkg.sv
package ckg_pkg;

    // Register addresses
    localparam logic [19:0] GATE_A_ADDR = 20'hf00f0;
    localparam logic [19:0] GATE_B_ADDR = 20'hf007a;
    localparam logic [19:0] DIV_SEL_ADDR = 20'hf00a8;
    localparam logic [19:0] SUBSYS_MODE_ADDR = 20'hf00f3;

    // Reset values and writable bit masks
    localparam logic [7:0] GATE_A_RST = 8'h00;
    localparam logic [7:0] GATE_B_RST = 8'h00;
    localparam logic [7:0] SUBSYS_RST = 8'h00;
    localparam logic [7:0] GATE_A_MASK = 8'hbd;
    localparam logic [7:0] GATE_B_MASK = 8'h19;
    localparam logic [7:0] SUBSYS_MASK = 8'h90;

    // Gate bit positions
    localparam int CAL_BIT = 7;
    localparam int CONV_BIT = 5;
    localparam int TWOWIRE_BIT = 4;
    localparam int SAU_ONE_BIT = 3;
    localparam int SAU_ZERO_BIT = 2;
    localparam int TAU_BIT = 0;
    localparam int EVT_BIT = 4;
    localparam int XFER_BIT = 3;
    localparam int PULSE_BIT = 0;

    // Subsystem clock mode bits
    localparam int LOW_POWER_BIT = 7;
    localparam int SRC_SEL_BIT = 4;

    // Option byte fields
    localparam int OPT_FREQ_LSB = 0;
    localparam int OPT_BIT_THREE = 3;
    localparam int OPT_BIT_FOUR = 4;

    // Divider change-over timing in clocks
    localparam logic [1:0] OLD_FREQ_CLKS_M1 = 2'h2;
    localparam logic [1:0] NEW_WAIT_CLKS_M1 = 2'h2;

    typedef struct packed {
        logic calendar;
        logic converter;
        logic twowire;
        logic sau_one;
        logic sau_zero;
        logic timer_array;
        logic event_timer;
        logic transfer_ctrl;
        logic pulse_timer;
    } ckg_gate_t;

    typedef enum logic [2:0] {
        DIV_IDLE = 3'h1,
        DIV_OLD = 3'h2,
        DIV_WAIT = 3'h4
    } ckg_div_state_t;

    function automatic logic [5:0] fih_mhz(input logic [2:0] code, input logic b3);
        fih_mhz = b3 ? (6'h20 >> code) : (6'h18 >> code);
    endfunction

    function automatic logic code_ok(input logic [2:0] code, input logic b3);
        code_ok = b3 ? (code <= 3'h5) : (code <= 3'h3);
    endfunction

endpackage

//--- hw/ckg_top.sv
// Summary of operation
// - Reset clears both gate registers, all peripheral clocks stopped.
// - Calendar gate low stops clock, holds reset, blocks writes.
// - Converter gate low stops clock, holds reset, blocks writes.
// - Two-wire gate low stops clock, holds reset, blocks writes.
// - Gate-a bits 3 and 2 gate serial array one and zero.
// - Timer array gate low stops clock, holds reset, blocks writes.
// - Gate bit high supplies clock, releases reset, allows writes.
// - Gate-b bit 4 gates the event timer the same way.
// - Gate-b bit 3 gates the transfer controller clock.
// - Gate-b bit 0 gates the pulse timer the same way.
// - Subsystem clock mode register resets to zero.
// - Low-power bit withholds subsystem clock in stop or halt while the CPU runs on the subsystem clock.
// - Source select picks calendar clock and pulse timer source option.
// - Divider register loads the option frequency code at reset.
// - Divider code selects frequency per option bit three.
// - Option bit four runs oscillator at twice the system side.
// - Three clocks at old frequency, then three clocks wait.
// - Oscillator at 64 or 48 MHz reaches CPU halved.
// - Low-speed oscillator runs with watchdog or source select set.
`timescale 1ns/1ns
module ckg_top (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // Special register port
    input wire logic [19:0] SPECIAL_REG_ADDR_I,
    input wire logic SPECIAL_REG_WR_I,
    input wire logic SPECIAL_REG_RD_I,
    input wire logic [7:0] SPECIAL_REG_WDATA_I,
    output logic [7:0] SPECIAL_REG_RDATA_O,
    // Option byte and system state
    input wire logic [7:0] OPTION_BYTE_I,
    input wire logic STOP_I,
    input wire logic HALT_I,
    input wire logic SUBSYS_CPU_I,
    input wire logic FCLK_IS_HOCO_I,
    input wire logic WDT_RUN_I,
    // Peripheral gating
    output ckg_pkg::ckg_gate_t GATED_CLK_O,
    output ckg_pkg::ckg_gate_t PERIPH_RST_B_O,
    output ckg_pkg::ckg_gate_t PERIPH_WR_EN_O,
    // Subsystem clock control
    output logic SUB_PERIPH_EN_O,
    output logic CAL_SRC_LOWSPEED_O,
    output logic PULSE_LOWSPEED_OK_O,
    output logic LOCO_RUN_O,
    // Oscillator divider
    output logic [5:0] FIH_MHZ_O,
    output logic [6:0] HOCO_MHZ_O,
    output logic HOCO_DOUBLE_O,
    output logic CPU_HALVE_O,
    output logic DIV_BUSY_O,
    output logic DIV_STALL_O
);
    logic [7:0] gate_a_q;
    logic [7:0] gate_b_q;
    logic [7:0] subsys_q;
    logic [7:0] rdata_q;
    logic sub_en_q;
    logic loco_q;
    logic [5:0] fih_q;
    logic [6:0] hoco_q;
    logic halve_q;
    logic wr_gate_a;
    logic wr_gate_b;
    logic wr_subsys;
    logic wr_div;
    logic [2:0] div_reg_code;
    logic [2:0] div_act_code;
    logic div_busy;
    logic div_stall;
    logic opt_b3;
    logic opt_b4;
    logic [2:0] opt_code;
    logic low_power_cond;
    ckg_pkg::ckg_gate_t gate_en;
    logic [8:0] gate_vec;
    logic [8:0] gclk_vec;

    assign opt_b3 = OPTION_BYTE_I[ckg_pkg::OPT_BIT_THREE];
    assign opt_b4 = OPTION_BYTE_I[ckg_pkg::OPT_BIT_FOUR];
    assign opt_code = OPTION_BYTE_I[ckg_pkg::OPT_FREQ_LSB +: 3];

    // Address decode
    assign wr_gate_a = SPECIAL_REG_WR_I && (SPECIAL_REG_ADDR_I == ckg_pkg::GATE_A_ADDR);
    assign wr_gate_b = SPECIAL_REG_WR_I && (SPECIAL_REG_ADDR_I == ckg_pkg::GATE_B_ADDR);
    assign wr_subsys = SPECIAL_REG_WR_I && (SPECIAL_REG_ADDR_I == ckg_pkg::SUBSYS_MODE_ADDR);
    assign wr_div = SPECIAL_REG_WR_I && (SPECIAL_REG_ADDR_I == ckg_pkg::DIV_SEL_ADDR) && FCLK_IS_HOCO_I;

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            gate_a_q <= ckg_pkg::GATE_A_RST;
        end else if (wr_gate_a) begin
            gate_a_q <= SPECIAL_REG_WDATA_I & ckg_pkg::GATE_A_MASK;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            gate_b_q <= ckg_pkg::GATE_B_RST;
        end else if (wr_gate_b) begin
            gate_b_q <= SPECIAL_REG_WDATA_I & ckg_pkg::GATE_B_MASK;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            subsys_q <= ckg_pkg::SUBSYS_RST;
        end else if (wr_subsys) begin
            subsys_q <= SPECIAL_REG_WDATA_I & ckg_pkg::SUBSYS_MASK;
        end
    end

    // Read data, unmapped reads zero
    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            rdata_q <= 8'h00;
        end else if (SPECIAL_REG_RD_I) begin
            case (SPECIAL_REG_ADDR_I)
                ckg_pkg::GATE_A_ADDR: begin
                    rdata_q <= gate_a_q;
                end
                ckg_pkg::GATE_B_ADDR: begin
                    rdata_q <= gate_b_q;
                end
                ckg_pkg::SUBSYS_MODE_ADDR: begin
                    rdata_q <= subsys_q;
                end
                ckg_pkg::DIV_SEL_ADDR: begin
                    rdata_q <= {5'h00, div_reg_code};
                end
                default: begin
                    rdata_q <= 8'h00;
                end
            endcase
        end
    end

    assign SPECIAL_REG_RDATA_O = rdata_q;

    assign gate_en.calendar = gate_a_q[ckg_pkg::CAL_BIT];
    assign gate_en.converter = gate_a_q[ckg_pkg::CONV_BIT];
    assign gate_en.twowire = gate_a_q[ckg_pkg::TWOWIRE_BIT];
    assign gate_en.sau_one = gate_a_q[ckg_pkg::SAU_ONE_BIT];
    assign gate_en.sau_zero = gate_a_q[ckg_pkg::SAU_ZERO_BIT];
    assign gate_en.timer_array = gate_a_q[ckg_pkg::TAU_BIT];
    assign gate_en.event_timer = gate_b_q[ckg_pkg::EVT_BIT];
    assign gate_en.transfer_ctrl = gate_b_q[ckg_pkg::XFER_BIT];
    assign gate_en.pulse_timer = gate_b_q[ckg_pkg::PULSE_BIT];

    assign PERIPH_RST_B_O = gate_en;
    assign PERIPH_WR_EN_O = gate_en;

    assign gate_vec = gate_en;

    for (genvar g = 0; g < 9; g++) begin : g_gate
        ckg_clk_gate u_gate (
            .clk_i(CLK_I),
            .en_i(gate_vec[g]),
            .gclk_o(gclk_vec[g])
        );
    end

    assign GATED_CLK_O = gclk_vec;

    assign low_power_cond = subsys_q[ckg_pkg::LOW_POWER_BIT] && SUBSYS_CPU_I && (STOP_I || HALT_I);

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            sub_en_q <= 1'b1;
        end else begin
            sub_en_q <= !low_power_cond;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            loco_q <= 1'b0;
        end else begin
            loco_q <= WDT_RUN_I || subsys_q[ckg_pkg::SRC_SEL_BIT];
        end
    end

    assign SUB_PERIPH_EN_O = sub_en_q;
    assign LOCO_RUN_O = loco_q;
    assign CAL_SRC_LOWSPEED_O = subsys_q[ckg_pkg::SRC_SEL_BIT];
    assign PULSE_LOWSPEED_OK_O = subsys_q[ckg_pkg::SRC_SEL_BIT];

    ckg_hoco_div u_div (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .opt_code_i(opt_code),
        .opt_b3_i(opt_b3),
        .wr_i(wr_div),
        .wr_code_i(SPECIAL_REG_WDATA_I[2:0]),
        .reg_code_o(div_reg_code),
        .act_code_o(div_act_code),
        .busy_o(div_busy),
        .stall_o(div_stall)
    );

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            fih_q <= 6'h00;
        end else begin
            fih_q <= ckg_pkg::fih_mhz(div_act_code, opt_b3);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            hoco_q <= 7'h00;
        end else if (opt_b4) begin
            hoco_q <= {ckg_pkg::fih_mhz(div_act_code, opt_b3), 1'b0};
        end else begin
            hoco_q <= {1'b0, ckg_pkg::fih_mhz(div_act_code, opt_b3)};
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_B_I) begin
            halve_q <= 1'b0;
        end else begin
            halve_q <= opt_b4 && (div_act_code == 3'h0);
        end
    end

    assign FIH_MHZ_O = fih_q;
    assign HOCO_MHZ_O = hoco_q;
    assign HOCO_DOUBLE_O = opt_b4;
    assign CPU_HALVE_O = halve_q;
    assign DIV_BUSY_O = div_busy;
    assign DIV_STALL_O = div_stall;

    default clocking cb @(posedge CLK_I);
    endclocking

    default disable iff (!RST_B_I);

    sequence old_freq_s;
        (div_busy && !div_stall && $stable(div_act_code)) [*3];
    endsequence

    sequence new_wait_s;
        div_stall [*3];
    endsequence

    gate_reset_a: assert property (@(posedge CLK_I) disable iff (1'b0)
        !RST_B_I |=> (gate_a_q == 8'h00) && (gate_b_q == 8'h00))
        else $error("gate registers not cleared by reset");

    cal_gate_off_a: assert property (
        wr_gate_a && !SPECIAL_REG_WDATA_I[7] |=> !PERIPH_RST_B_O.calendar && !PERIPH_WR_EN_O.calendar)
        else $error("calendar not held after gate clear");

    conv_gate_off_a: assert property (
        wr_gate_a && !SPECIAL_REG_WDATA_I[5] |=> !PERIPH_RST_B_O.converter && !PERIPH_WR_EN_O.converter)
        else $error("converter not held after gate clear");

    twowire_gate_a: assert property (
        wr_gate_a |=> PERIPH_WR_EN_O.twowire == $past(SPECIAL_REG_WDATA_I[4]))
        else $error("two-wire gate does not follow write");

    sau_gates_a: assert property (
        wr_gate_a |=> {PERIPH_RST_B_O.sau_one, PERIPH_RST_B_O.sau_zero} == $past(SPECIAL_REG_WDATA_I[3:2]))
        else $error("serial array gates do not follow write");

    tau_gate_a: assert property (
        wr_gate_a && !SPECIAL_REG_WDATA_I[0] |=> !PERIPH_WR_EN_O.timer_array [*2] or wr_gate_a)
        else $error("timer array gate not held");

    gate_enable_a: assert property (
        wr_gate_a && SPECIAL_REG_WDATA_I[7] |=> PERIPH_RST_B_O.calendar && PERIPH_WR_EN_O.calendar)
        else $error("calendar not released after gate set");

    event_gate_a: assert property (
        wr_gate_b |=> PERIPH_RST_B_O.event_timer == $past(SPECIAL_REG_WDATA_I[4]))
        else $error("event timer gate does not follow write");

    xfer_gate_a: assert property (
        wr_gate_b |=> PERIPH_WR_EN_O.transfer_ctrl == $past(SPECIAL_REG_WDATA_I[3]))
        else $error("transfer controller gate does not follow write");

    pulse_gate_a: assert property (
        wr_gate_b |=> PERIPH_RST_B_O.pulse_timer == $past(SPECIAL_REG_WDATA_I[0]))
        else $error("pulse timer gate does not follow write");

    mode_reset_a: assert property (@(posedge CLK_I) disable iff (1'b0)
        !RST_B_I |=> subsys_q == 8'h00)
        else $error("subsystem mode register not cleared");

    sub_withhold_a: assert property (
        low_power_cond |=> !SUB_PERIPH_EN_O)
        else $error("subsystem clock not withheld");

    src_select_a: assert property (
        wr_subsys |=> CAL_SRC_LOWSPEED_O == $past(SPECIAL_REG_WDATA_I[4]))
        else $error("source select does not follow write");

    div_reset_a: assert property (@(posedge CLK_I) disable iff (1'b0)
        !RST_B_I |=> div_reg_code == $past(opt_code))
        else $error("divider code not loaded from option");

    freq_code_a: assert property (
        !opt_b3 && $stable(div_act_code) && div_act_code == 3'h1 |=> FIH_MHZ_O == 6'h0c)
        else $error("code one does not give 12 MHz");

    double_rate_a: assert property (
        opt_b4 ##1 opt_b4 |-> HOCO_MHZ_O == {FIH_MHZ_O, 1'b0})
        else $error("oscillator not at twice system rate");

    div_change_a: assert property (
        $rose(div_busy) |-> old_freq_s ##1 new_wait_s ##1 !div_busy)
        else $error("divider change-over timing wrong");

    cpu_halve_a: assert property (
        opt_b4 && div_act_code == 3'h0 |=> CPU_HALVE_O)
        else $error("CPU clock not halved at top rate");

    loco_run_a: assert property (
        WDT_RUN_I || subsys_q[4] |=> LOCO_RUN_O)
        else $error("low-speed oscillator not running");

endmodule

//--- sim/ckg_periph_model.sv
`timescale 1ns/1ns
module ckg_periph_model (
    // Gating from the block
    input wire ckg_pkg::ckg_gate_t gclk_i,
    input wire ckg_pkg::ckg_gate_t rst_b_i,
    // Activity seen by each unit
    output wire logic [8:0][7:0] edges_o,
    output wire logic [8:0] glitch_o
);
    for (genvar i = 0; i < 9; i++) begin : g_unit
        logic [7:0] cnt_q;
        logic bad;
        time rise_t;
        initial begin
            bad = 1'b0;
            rise_t = 0;
        end
        always @(posedge gclk_i[i] or negedge rst_b_i[i]) begin
            if (!rst_b_i[i]) begin
                cnt_q <= 8'h00;
            end else if (cnt_q != 8'hff) begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
        always @(posedge gclk_i[i]) begin
            rise_t = $time;
        end
        always @(negedge gclk_i[i]) begin
            if (rise_t > 0 && $time - rise_t < 20) begin
                bad = 1'b1;
            end
        end
        assign edges_o[i] = cnt_q;
        assign glitch_o[i] = bad;
    end
endmodule

//--- sim/test_peripheral_clock_gate_and_hoco_divider.sv
`timescale 1ns/1ns
module test_peripheral_clock_gate_and_hoco_divider;
    logic clk, rst_b, wr_s, rd_s, stop, halt, sub_cpu, fclk_hoco, wdt;
    logic [19:0] addr;
    logic [7:0] wdata, rdata, opt, va, vb;
    ckg_pkg::ckg_gate_t gclk, prst_b, pwr_en;
    logic sub_en, cal_lo, pulse_ok, loco, dbl, halve, busy, stall;
    logic [5:0] fih, cur;
    logic [6:0] hoco;
    wire logic [8:0][7:0] edges;
    wire logic [8:0] glitch;
    logic rd_seen = 1'b0;
    logic [8:0] act;
    logic [7:0] exp_q[$];
    string what_q[$];
    int mismatches = 0;
    int total_checks = 0;
    localparam logic [7:0] GBIT [9] = '{8'h01, 8'h08, 8'h10, 8'h01, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};

    ckg_top u_ckg_top (.CLK_I(clk), .RST_B_I(rst_b), .SPECIAL_REG_ADDR_I(addr), .SPECIAL_REG_WR_I(wr_s),
        .SPECIAL_REG_RD_I(rd_s), .SPECIAL_REG_WDATA_I(wdata), .SPECIAL_REG_RDATA_O(rdata),
        .OPTION_BYTE_I(opt), .STOP_I(stop), .HALT_I(halt), .SUBSYS_CPU_I(sub_cpu), .FCLK_IS_HOCO_I(fclk_hoco),
        .WDT_RUN_I(wdt), .GATED_CLK_O(gclk),
        .PERIPH_RST_B_O(prst_b), .PERIPH_WR_EN_O(pwr_en), .SUB_PERIPH_EN_O(sub_en),
        .CAL_SRC_LOWSPEED_O(cal_lo), .PULSE_LOWSPEED_OK_O(pulse_ok), .LOCO_RUN_O(loco), .FIH_MHZ_O(fih),
        .HOCO_MHZ_O(hoco), .HOCO_DOUBLE_O(dbl), .CPU_HALVE_O(halve), .DIV_BUSY_O(busy), .DIV_STALL_O(stall));

    ckg_periph_model u_ckg_periph_model (.gclk_i(gclk), .rst_b_i(prst_b), .edges_o(edges), .glitch_o(glitch));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Read results compared in arrival order
    always @(posedge clk) begin
        if (rd_seen) begin
            check(what_q.pop_front(), 9'(rdata), 9'(exp_q.pop_front()));
        end
        rd_seen <= rd_s;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        idle(1);
        addr = a;
        wdata = d;
        wr_s = 1'b1;
        idle(1);
        wr_s = 1'b0;
    endtask

    task automatic rd(input logic [19:0] a, input logic [7:0] e, input string w);
        idle(1);
        exp_q.push_back(e);
        what_q.push_back(w);
        addr = a;
        rd_s = 1'b1;
        idle(1);
        rd_s = 1'b0;
    endtask

    task automatic do_reset(input logic [7:0] o);
        opt = o;
        rst_b = 1'b0;
        idle(20);
        rst_b = 1'b1;
        idle(3);
    endtask

    task automatic div_change(input logic [2:0] c, input logic [5:0] old_f, input logic [5:0] new_f, input logic b4);
        int n_old;
        int n_new;
        bit seen;
        n_old = 0;
        n_new = 0;
        seen = 0;
        wr(ckg_pkg::DIV_SEL_ADDR, {5'h00, c});
        for (int k = 0; k < 12; k++) begin
            if (busy === 1'b1) begin
                seen = 1;
                if (stall === 1'b1) begin
                    n_new++;
                end else begin
                    n_old++;
                    check("fih old", 9'(fih), 9'(old_f));
                end
            end else if (seen) begin
                break;
            end
            idle(1);
        end
        if (!seen || busy !== 1'b0) begin
            mismatches++;
            $display("wrong value divider busy expected end seen none");
            end_sim();
        end
        check("old clocks", 9'(n_old), 9'h003);
        check("wait clocks", 9'(n_new), 9'h003);
        check("fih", 9'(fih), 9'(new_f));
        check("hoco", 9'(hoco), 9'(b4 ? {new_f, 1'b0} : {1'b0, new_f}));
        check("halve", 9'(halve), 9'(b4 && c == 3'h0));
        rd(ckg_pkg::DIV_SEL_ADDR, {5'h00, c}, "div code");
    endtask

    task automatic div_refuse(input logic [2:0] c, input logic [2:0] keep);
        wr(ckg_pkg::DIV_SEL_ADDR, {5'h00, c});
        idle(3);
        check("busy", 9'(busy), 9'h000);
        rd(ckg_pkg::DIV_SEL_ADDR, {5'h00, keep}, "div kept");
    endtask

    initial begin
        {rst_b, wr_s, rd_s, stop, halt, sub_cpu, wdt} = '0;
        fclk_hoco = 1'b1;
        addr = '0;
        wdata = '0;
        opt = 8'h0a;
        void'($urandom(17));
        do_reset(8'h0a);
        check("reset gates", prst_b, 9'h000);
        check("reset wren", pwr_en, 9'h000);
        rd(ckg_pkg::GATE_A_ADDR, 8'h00, "gate a");
        rd(ckg_pkg::GATE_B_ADDR, 8'h00, "gate b");
        rd(ckg_pkg::SUBSYS_MODE_ADDR, 8'h00, "mode");
        for (int i = 0; i < 9; i++) begin
            wr(i < 3 ? ckg_pkg::GATE_B_ADDR : ckg_pkg::GATE_A_ADDR, GBIT[i]);
            check("unit reset", prst_b, 9'h001 << i);
            check("unit write", pwr_en, 9'h001 << i);
            idle(4);
            for (int j = 0; j < 9; j++) act[j] = edges[j] != 8'h00;
            check("unit clock", act, 9'h001 << i);
            wr(i < 3 ? ckg_pkg::GATE_B_ADDR : ckg_pkg::GATE_A_ADDR, 8'h00);
        end
        for (int k = 0; k < 8; k++) begin
            va = 8'($urandom) & ckg_pkg::GATE_A_MASK;
            vb = 8'($urandom) & ckg_pkg::GATE_B_MASK;
            wr(ckg_pkg::GATE_A_ADDR, va);
            wr(ckg_pkg::GATE_B_ADDR, vb);
            check("gate map", prst_b, {va[7], va[5:2], va[0], vb[4:3], vb[0]});
            rd(ckg_pkg::GATE_A_ADDR, va, "gate a");
            rd(ckg_pkg::GATE_B_ADDR, vb, "gate b");
        end
        wr(ckg_pkg::GATE_A_ADDR, 8'h00);
        wr(ckg_pkg::GATE_B_ADDR, 8'h00);
        wr(ckg_pkg::SUBSYS_MODE_ADDR, 8'h10);
        rd(ckg_pkg::SUBSYS_MODE_ADDR, 8'h10, "mode");
        idle(2);
        check("cal src", 9'(cal_lo), 9'h001);
        check("pulse src", 9'(pulse_ok), 9'h001);
        check("loco", 9'(loco), 9'h001);
        wr(ckg_pkg::SUBSYS_MODE_ADDR, 8'h00);
        wdt = 1'b1;
        idle(2);
        check("cal src", 9'(cal_lo), 9'h000);
        check("pulse src", 9'(pulse_ok), 9'h000);
        check("loco", 9'(loco), 9'h001);
        wdt = 1'b0;
        idle(2);
        check("loco", 9'(loco), 9'h000);
        for (int k = 0; k < 16; k++) begin
            wr(ckg_pkg::SUBSYS_MODE_ADDR, {k[0], 7'h00});
            sub_cpu = k[1];
            stop = k[2];
            halt = k[3];
            idle(2);
            check("sub clock", 9'(sub_en), 9'(!(k[0] && k[1] && (k[2] || k[3]))));
        end
        {sub_cpu, stop, halt} = '0;
        check("fih reset", 9'(fih), 9'h008);
        check("double", 9'(dbl), 9'h000);
        rd(ckg_pkg::DIV_SEL_ADDR, 8'h02, "div reset");
        cur = 6'h08;
        for (int c = 0; c < 6; c++) begin
            div_change(3'(c), cur, 6'h20 >> c, 1'b0);
            cur = 6'h20 >> c;
        end
        div_refuse(3'h6, 3'h5);
        fclk_hoco = 1'b0;
        div_refuse(3'h1, 3'h5);
        fclk_hoco = 1'b1;
        do_reset(8'h18);
        check("fih", 9'(fih), 9'h020);
        check("hoco", 9'(hoco), 9'h040);
        check("double", 9'(dbl), 9'h001);
        check("halve", 9'(halve), 9'h001);
        wr(ckg_pkg::GATE_B_ADDR, 8'h10);
        check("event gate", prst_b, 9'h004);
        wr(ckg_pkg::GATE_B_ADDR, 8'h00);
        div_change(3'h2, 6'h20, 6'h08, 1'b1);
        do_reset(8'h01);
        check("fih", 9'(fih), 9'h00c);
        div_refuse(3'h4, 3'h1);
        div_change(3'h3, 6'h0c, 6'h03, 1'b0);
        div_change(3'h0, 6'h03, 6'h18, 1'b0);
        // Doubled oscillator with option bit three clear
        do_reset(8'h10);
        check("fih", 9'(fih), 9'h018);
        check("hoco", 9'(hoco), 9'h030);
        check("halve", 9'(halve), 9'h001);
        div_change(3'h1, 6'h18, 6'h0c, 1'b1);
        check("glitch", glitch, 9'h000);
        idle(3);
        end_sim();
    end
endmodule
